//--- core/sfd_pkg.sv
package sfd_pkg;

  // ---------------------------------------------------------------------------
  // register offsets (byte addresses, one word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OFF_FEATURE_SELECT = 8'h00;
  localparam logic [7:0] OFF_SECTOR_COUNT   = 8'h04;
  localparam logic [7:0] OFF_ADDR_LOW       = 8'h08;
  localparam logic [7:0] OFF_ADDR_MID       = 8'h0C;
  localparam logic [7:0] OFF_ADDR_HIGH      = 8'h10;
  localparam logic [7:0] OFF_DRIVE_SELECT   = 8'h14;
  localparam logic [7:0] OFF_COMMAND_CODE   = 8'h18;
  localparam logic [7:0] OFF_ERROR_FLAGS    = 8'h1C;
  localparam logic [7:0] OFF_STATUS         = 8'h20;
  localparam logic [7:0] OFF_SETTINGS       = 8'h24;

  // ---------------------------------------------------------------------------
  // command and subcommand codes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] CMD_SERVICE      = 8'hA2;
  localparam logic [7:0] CMD_SET_FEATURES = 8'hEF;
  localparam logic [7:0] SUB_NARROW_ON    = 8'h01;
  localparam logic [7:0] SUB_WCACHE_ON    = 8'h02;
  localparam logic [7:0] SUB_XFER_MODE    = 8'h03;
  localparam logic [7:0] SUB_APM_ON       = 8'h05;
  localparam logic [7:0] SUB_LOOKAHEAD_OFF = 8'h55;
  localparam logic [7:0] SUB_REL_INT_ON   = 8'h5D;
  localparam logic [7:0] SUB_SVC_INT_ON   = 8'h5E;
  localparam logic [7:0] SUB_NARROW_OFF   = 8'h81;
  localparam logic [7:0] SUB_WCACHE_OFF   = 8'h82;
  localparam logic [7:0] SUB_APM_OFF      = 8'h85;
  localparam logic [7:0] SUB_LOOKAHEAD_ON = 8'hAA;
  localparam logic [7:0] SUB_REL_INT_OFF  = 8'hDD;
  localparam logic [7:0] SUB_SVC_INT_OFF  = 8'hDE;

  // ---------------------------------------------------------------------------
  // transfer mode types and power levels
  // ---------------------------------------------------------------------------
  localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
  localparam logic [4:0] XT_PIO_FLOW    = 5'h01;
  localparam logic [4:0] XT_MDMA        = 5'h04;
  localparam logic [4:0] XT_UDMA        = 5'h08;
  localparam logic [2:0] XM_DEFAULT     = 3'h0;
  localparam logic [2:0] XM_NO_FLOW     = 3'h1;
  localparam logic [2:0] PIO_FLOW_MIN   = 3'h3;
  localparam logic [7:0] APM_RSVD_LOW   = 8'h00;
  localparam logic [7:0] APM_RSVD_HIGH  = 8'hFF;
  localparam logic [7:0] APM_NO_STANDBY = 8'h80;

  // ---------------------------------------------------------------------------
  // device capabilities
  // ---------------------------------------------------------------------------
  localparam logic       CAP_NARROW     = 1'b1;
  localparam logic       CAP_FLOW_OFF   = 1'b1;
  localparam logic       CAP_APM_OFF    = 1'b1;
  localparam logic [2:0] CAP_PIO_MAX    = 3'h4;
  localparam logic [2:0] CAP_MDMA_MAX   = 3'h2;
  localparam logic [2:0] CAP_UDMA_MAX   = 3'h5;

  // ---------------------------------------------------------------------------
  // status and error bit positions
  // ---------------------------------------------------------------------------
  localparam int BIT_BUSY  = 7;
  localparam int BIT_READY = 6;
  localparam int BIT_FAULT = 5;
  localparam int BIT_SREQ  = 4;
  localparam int BIT_DREQ  = 3;
  localparam int BIT_ERR   = 0;
  localparam int BIT_ABORT = 2;
  localparam logic [7:0] ERR_ABORT = 8'h04;

  typedef enum {ST_IDLE, ST_EXEC, ST_FLUSH} sfd_state_e;

  typedef struct packed {
    logic       wcache_en;
    logic       narrow_en;
    logic       flow_en;
    logic [2:0] pio_mode;
    logic       mdma_en;
    logic [2:0] mdma_mode;
    logic       udma_en;
    logic [2:0] udma_mode;
    logic       apm_en;
    logic [7:0] apm_level;
    logic       rel_int_en;
    logic       svc_int_en;
    logic       lookahead_en;
  } sfd_feat_s;

  localparam sfd_feat_s FEAT_RST = '{
    wcache_en: 1'b1, narrow_en: 1'b0, flow_en: 1'b1, pio_mode: 3'h0,
    mdma_en: 1'b0, mdma_mode: 3'h0, udma_en: 1'b0, udma_mode: 3'h0,
    apm_en: 1'b0, apm_level: 8'hFE, rel_int_en: 1'b0, svc_int_en: 1'b0,
    lookahead_en: 1'b1};

endpackage : sfd_pkg

//--- core/sfd_top.sv
// Operation
// - service only after release with service-request set
// - service resumes transfer or status of released command
// - set-features code in feature, params elsewhere
// - unsupported or invalid input aborts, abort flag
// - error completion: busy, data request clear, ready
// - write cache on/off; disable flushes before completion
// - narrow PIO only with compact-card support
// - sector count 7:3 type, 2:0 mode
// - transfer type codes; retired and reserved abort
// - 00h default PIO, 01h default without flow
// - ultra and multiword DMA mutually exclusive
// - flow control on for PIO mode three up
// - every mode up to and including family maximum accepted
// - power level from sector count on 05h
// - power level encoding, 00h and FFh reserved
// - level 80h or above forbids spin down
// - 85h disables power management or aborts
// - separate release and service interrupt enables
// - one look-ahead enable, 55h off AAh on
// - reserved and obsolete subcommands abort
// - service data request raises pending when enabled
// - bus release raises pending when enabled
module sfd_top (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              service_request_bit,
  input  wire logic              bus_release,
  input  wire logic              resume_has_data,
  input  wire logic              data_done,
  input  wire logic              dev_fault,
  input  wire logic              flush_done,
  output logic                   svc_resume,
  output logic                   flush_req,
  output sfd_pkg::sfd_feat_s     feat,
  output logic                   narrow_bus,
  output logic                   ready_flow_control_signal,
  output logic                   spin_down_ok,
  output logic                   int_pending
);
  import sfd_pkg::*;

  // ---------------------------------------------------------------------------
  // bus slave
  // ---------------------------------------------------------------------------
  logic       ap_take;
  logic       ap_hit;
  logic       dp_wr_r;
  logic [7:0] dp_addr_r;
  logic [31:0] hrdata_r;
  logic [31:0] rd_mux;
  logic       rd_status;

  assign ap_take   = hsel & htrans[1] & hready;
  assign ap_hit    = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_r;
  assign rd_status = ap_take & ~hwrite & ap_hit & (haddr[7:0] == OFF_STATUS);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
      hrdata_r  <= 32'h00000000;
    end else begin
      dp_wr_r   <= ap_take & hwrite & ap_hit;
      dp_addr_r <= haddr[7:0];
      if (ap_take && !hwrite) begin
        hrdata_r <= ap_hit ? rd_mux : 32'h00000000;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // task file registers
  // ---------------------------------------------------------------------------
  logic [7:0] feature_select_r;
  logic [7:0] sector_count_param_r;
  logic [7:0] addr_low_param_r;
  logic [7:0] addr_mid_param_r;
  logic [7:0] addr_high_param_r;
  logic [7:0] drive_select_r;
  logic [7:0] command_code_r;
  logic [7:0] error_flags_r;
  logic [7:0] status;
  sfd_state_e state_r;
  logic       cmd_start;
  logic       busy;

  assign busy      = (state_r != ST_IDLE);
  assign cmd_start = dp_wr_r & (dp_addr_r == OFF_COMMAND_CODE) & ~busy;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feature_select_r     <= 8'h00;
      sector_count_param_r <= 8'h00;
      addr_low_param_r     <= 8'h00;
      addr_mid_param_r     <= 8'h00;
      addr_high_param_r    <= 8'h00;
      drive_select_r       <= 8'h00;
    end else if (dp_wr_r) begin
      unique case (dp_addr_r)
        OFF_FEATURE_SELECT: feature_select_r     <= hwdata[7:0];
        OFF_SECTOR_COUNT:   sector_count_param_r <= hwdata[7:0];
        OFF_ADDR_LOW:       addr_low_param_r     <= hwdata[7:0];
        OFF_ADDR_MID:       addr_mid_param_r     <= hwdata[7:0];
        OFF_ADDR_HIGH:      addr_high_param_r    <= hwdata[7:0];
        OFF_DRIVE_SELECT:   drive_select_r       <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      command_code_r <= 8'h00;
    end else if (cmd_start) begin
      command_code_r <= hwdata[7:0];
    end
  end

  always_comb begin
    rd_mux = 32'h00000000;
    unique case (haddr[7:0])
      OFF_SECTOR_COUNT: rd_mux = {24'h000000, sector_count_param_r};
      OFF_ADDR_LOW:     rd_mux = {24'h000000, addr_low_param_r};
      OFF_ADDR_MID:     rd_mux = {24'h000000, addr_mid_param_r};
      OFF_ADDR_HIGH:    rd_mux = {24'h000000, addr_high_param_r};
      OFF_DRIVE_SELECT: rd_mux = {24'h000000, drive_select_r};
      OFF_ERROR_FLAGS:  rd_mux = {24'h000000, error_flags_r};
      OFF_STATUS:       rd_mux = {24'h000000, status};
      OFF_SETTINGS:     rd_mux = {6'h00, feat};
      default:          rd_mux = 32'h00000000;
    endcase
  end

  // ---------------------------------------------------------------------------
  // set-features decode
  // ---------------------------------------------------------------------------
  sfd_feat_s  feat_r;
  sfd_feat_s  feat_nxt;
  logic       sf_abort;
  logic       sf_flush;
  logic [4:0] xfer_type;
  logic [2:0] xfer_mode;

  assign xfer_type = sector_count_param_r[7:3];
  assign xfer_mode = sector_count_param_r[2:0];

  always_comb begin
    feat_nxt = feat_r;
    sf_abort = 1'b0;
    sf_flush = 1'b0;
    case (feature_select_r)
      SUB_WCACHE_ON:     feat_nxt.wcache_en = 1'b1;
      SUB_WCACHE_OFF:    sf_flush = 1'b1;
      SUB_NARROW_ON: begin
        feat_nxt.narrow_en = 1'b1;
        sf_abort = ~CAP_NARROW;
      end
      SUB_NARROW_OFF: begin
        feat_nxt.narrow_en = 1'b0;
        sf_abort = ~CAP_NARROW;
      end
      SUB_XFER_MODE: begin
        case (xfer_type)
          XT_PIO_DEFAULT: begin
            feat_nxt.pio_mode = 3'h0;
            if (xfer_mode == XM_DEFAULT) begin
              feat_nxt.flow_en = 1'b1;
            end else if (xfer_mode == XM_NO_FLOW && CAP_FLOW_OFF) begin
              feat_nxt.flow_en = 1'b0;
            end else begin
              sf_abort = 1'b1;
            end
          end
          XT_PIO_FLOW: begin
            feat_nxt.pio_mode = xfer_mode;
            feat_nxt.flow_en  = 1'b1;
            sf_abort = (xfer_mode > CAP_PIO_MAX);
          end
          XT_MDMA: begin
            feat_nxt.mdma_en   = 1'b1;
            feat_nxt.mdma_mode = xfer_mode;
            feat_nxt.udma_en   = 1'b0;
            sf_abort = (xfer_mode > CAP_MDMA_MAX);
          end
          XT_UDMA: begin
            feat_nxt.udma_en   = 1'b1;
            feat_nxt.udma_mode = xfer_mode;
            feat_nxt.mdma_en   = 1'b0;
            sf_abort = (xfer_mode > CAP_UDMA_MAX);
          end
          default: sf_abort = 1'b1;
        endcase
      end
      SUB_APM_ON: begin
        feat_nxt.apm_en    = 1'b1;
        feat_nxt.apm_level = sector_count_param_r;
        sf_abort = (sector_count_param_r == APM_RSVD_LOW) |
                   (sector_count_param_r == APM_RSVD_HIGH);
      end
      SUB_APM_OFF: begin
        feat_nxt.apm_en = 1'b0;
        sf_abort = ~CAP_APM_OFF;
      end
      SUB_REL_INT_ON:    feat_nxt.rel_int_en   = 1'b1;
      SUB_REL_INT_OFF:   feat_nxt.rel_int_en   = 1'b0;
      SUB_SVC_INT_ON:    feat_nxt.svc_int_en   = 1'b1;
      SUB_SVC_INT_OFF:   feat_nxt.svc_int_en   = 1'b0;
      SUB_LOOKAHEAD_ON:  feat_nxt.lookahead_en = 1'b1;
      SUB_LOOKAHEAD_OFF: feat_nxt.lookahead_en = 1'b0;
      default:           sf_abort = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------------------
  // command sequencer
  // ---------------------------------------------------------------------------
  logic exec_abort;
  logic exec_done;
  logic svc_ok;
  logic svc_dreq;
  logic flush_fin;

  assign svc_ok     = (command_code_r == CMD_SERVICE) & service_request_bit;
  assign svc_dreq   = svc_ok & resume_has_data;
  assign exec_abort = (state_r == ST_EXEC) &
                      ((command_code_r == CMD_SET_FEATURES) ? sf_abort : ~svc_ok);
  assign exec_done  = (state_r == ST_EXEC) &
                      ~((command_code_r == CMD_SET_FEATURES) & sf_flush & ~sf_abort);
  assign flush_fin  = (state_r == ST_FLUSH) & flush_done;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE:  if (cmd_start) state_r <= ST_EXEC;
        ST_EXEC:  state_r <= exec_done ? ST_IDLE : ST_FLUSH;
        ST_FLUSH: if (flush_done) state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      feat_r <= FEAT_RST;
    end else if (flush_fin) begin
      feat_r.wcache_en <= 1'b0;
    end else if (exec_done && !exec_abort && command_code_r == CMD_SET_FEATURES) begin
      feat_r <= feat_nxt;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      error_flags_r <= 8'h00;
    end else if (cmd_start) begin
      error_flags_r <= 8'h00;
    end else if (exec_done) begin
      error_flags_r <= exec_abort ? ERR_ABORT : 8'h00;
    end
  end

  logic dreq_r;
  logic svc_resume_r;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dreq_r       <= 1'b0;
      svc_resume_r <= 1'b0;
    end else begin
      svc_resume_r <= (state_r == ST_EXEC) & svc_ok;
      if (exec_done && svc_dreq) begin
        dreq_r <= 1'b1;
      end else if (exec_abort || data_done) begin
        dreq_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // interrupt pending, cleared by a status read
  // ---------------------------------------------------------------------------
  logic int_set;
  logic int_pending_r;

  assign int_set = (bus_release & feat_r.rel_int_en) |
                   (exec_done & svc_dreq & feat_r.svc_int_en) |
                   (exec_done & ~svc_dreq) | flush_fin;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_pending_r <= 1'b0;
    end else if (int_set) begin
      int_pending_r <= 1'b1;
    end else if (rd_status) begin
      int_pending_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // status and outputs
  // ---------------------------------------------------------------------------
  assign status[BIT_BUSY]  = busy;
  assign status[BIT_READY] = 1'b1;
  assign status[BIT_FAULT] = dev_fault;
  assign status[BIT_SREQ]  = service_request_bit;
  assign status[BIT_DREQ]  = dreq_r;
  assign status[2:1]       = 2'h0;
  assign status[BIT_ERR]   = |error_flags_r;

  assign feat         = feat_r;
  assign svc_resume   = svc_resume_r;
  assign flush_req    = (state_r == ST_FLUSH);
  assign narrow_bus   = feat_r.narrow_en;
  assign ready_flow_control_signal = feat_r.flow_en | (feat_r.pio_mode >= PIO_FLOW_MIN);
  assign spin_down_ok = ~(feat_r.apm_en & (feat_r.apm_level >= APM_NO_STANDBY));
  assign int_pending  = int_pending_r;

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_flush_start;
    state_r == ST_EXEC && !exec_done;
  endsequence
  sequence s_flush_end;
    flush_req ##1 !flush_req;
  endsequence

  property p_abort_err;
    exec_abort |=> error_flags_r[BIT_ABORT] && status[BIT_ERR] && !busy && !dreq_r;
  endproperty
  a_abort_err: assert property (p_abort_err) else $error("abort not reported");

  property p_keep_on_abort;
    exec_abort |=> $stable(feat_r);
  endproperty
  a_keep_on_abort: assert property (p_keep_on_abort) else $error("settings moved");

  property p_flush_busy;
    s_flush_start |=> flush_req && busy && feat_r.wcache_en;
  endproperty
  a_flush_busy: assert property (p_flush_busy) else $error("flush not started");

  property p_flush_done;
    s_flush_end |-> !feat_r.wcache_en && !busy;
  endproperty
  a_flush_done: assert property (p_flush_done) else $error("flush end wrong");

  property p_dma_excl;
    !(feat_r.udma_en && feat_r.mdma_en);
  endproperty
  a_dma_excl: assert property (p_dma_excl) else $error("both dma families on");

  property p_flow_pio;
    feat_r.pio_mode >= PIO_FLOW_MIN |-> ready_flow_control_signal;
  endproperty
  a_flow_pio: assert property (p_flow_pio) else $error("flow control off");

  property p_no_spin;
    feat_r.apm_en && feat_r.apm_level[7] |-> !spin_down_ok;
  endproperty
  a_no_spin: assert property (p_no_spin) else $error("spin down allowed");

  property p_rel_int;
    bus_release && feat_r.rel_int_en |=> int_pending;
  endproperty
  a_rel_int: assert property (p_rel_int) else $error("release int missing");

  property p_svc_int;
    exec_done && svc_dreq && feat_r.svc_int_en |=> int_pending && dreq_r;
  endproperty
  a_svc_int: assert property (p_svc_int) else $error("service int missing");

  property p_svc_gate;
    state_r == ST_EXEC && command_code_r == CMD_SERVICE && !service_request_bit
      |=> error_flags_r == ERR_ABORT && !svc_resume;
  endproperty
  a_svc_gate: assert property (p_svc_gate) else $error("service without request");

endmodule : sfd_top

//--- dv/sfd_bfm.sv
module sfd_bfm (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       flush_req,
  input  wire logic       svc_resume,
  input  wire logic [3:0] lat,
  output logic            flush_done,
  output logic            data_done
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] fcnt_r;
  logic [3:0] dcnt_r;
  logic       dbusy_r;
  // flush ends lat+1 cycles after the request appears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fcnt_r     <= 4'h0;
      flush_done <= 1'b0;
    end else if (flush_req && !flush_done) begin
      if (fcnt_r == lat) flush_done <= 1'b1;
      else fcnt_r <= fcnt_r + 4'h1;
    end else begin
      fcnt_r     <= 4'h0;
      flush_done <= 1'b0;
    end
  end
  // resumed transfer finishes lat+2 cycles after the resume
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dbusy_r   <= 1'b0;
      dcnt_r    <= 4'h0;
      data_done <= 1'b0;
    end else if (svc_resume) begin
      dbusy_r <= 1'b1;
      dcnt_r  <= 4'h0;
    end else if (dbusy_r && dcnt_r == lat) begin
      dbusy_r   <= 1'b0;
      data_done <= 1'b1;
    end else begin
      dcnt_r    <= dcnt_r + 4'h1;
      data_done <= 1'b0;
    end
  end
endmodule : sfd_bfm

//--- dv/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import sfd_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        service_request_bit = 1'b0;
  logic        bus_release = 1'b0;
  logic        resume_has_data = 1'b0;
  logic        dev_fault = 1'b0;
  logic [3:0]  lat = 4'h0;
  logic        hreadyout, hresp, svc_resume, flush_req, flush_done, data_done;
  logic        narrow_bus, ready_flow_control_signal, spin_down_ok, int_pending, en;
  logic [31:0] hrdata, v;
  sfd_feat_s   feat, ef;
  int          miscompares = 0, n_compared = 0, svc_n = 0, svc_exp = 0;
  localparam logic [4:0]  TT [3] = '{XT_PIO_FLOW, XT_MDMA, XT_UDMA};
  localparam logic        CABLE_80 = 1'b1;
  localparam logic [15:0] TBL [27] = '{16'h0322, 16'h8200, 16'h0200, 16'h0100, 16'h8100,
    16'h0301, 16'h0300, 16'h0580, 16'h057F, 16'h05FE, 16'h8500, 16'h5500, 16'hAA00,
    16'h8200, 16'h0200, 16'h0400, 16'h0310, 16'h0380, 16'h0302, 16'h0330, 16'h0500,
    16'h05FF, 16'h0900, 16'hF000, 16'h3300, 16'h0100, 16'h0380};

  sfd_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .service_request_bit(service_request_bit), .bus_release(bus_release),
    .resume_has_data(resume_has_data),
    .data_done(data_done), .dev_fault(dev_fault), .flush_done(flush_done),
    .svc_resume(svc_resume), .flush_req(flush_req), .feat(feat), .narrow_bus(narrow_bus),
    .ready_flow_control_signal(ready_flow_control_signal), .spin_down_ok(spin_down_ok),
    .int_pending(int_pending));
  sfd_bfm u_bfm (.hclk(hclk), .hresetn(hresetn), .flush_req(flush_req),
    .svc_resume(svc_resume), .lat(lat), .flush_done(flush_done), .data_done(data_done));

  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (svc_resume === 1'b1) svc_n <= svc_n + 1;

  // ---------------------------------------------------------------------------
  // bus cycles, checks, expected settings
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR at %0t: seen %0h expected %0h", $time, s, e);
    end
  endtask : chk

  task automatic aph(input logic [7:0] a, input logic w);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'b00;
  endtask : aph

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    aph(a, 1'b1);
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    aph(a, 1'b0);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask : rd

  task automatic wait_idle(output logic [31:0] d);
    for (int i = 0; i < 40; i++) begin
      rd(OFF_STATUS, d);
      if (d[7] === 1'b0) break;
    end
    chk({31'h0, d[7]}, 32'h0);
  endtask : wait_idle

  function automatic logic upd(input logic [7:0] s, input logic [7:0] c, inout sfd_feat_s f);
    logic ab;
    ab = 1'b0;
    case (s)
      SUB_WCACHE_ON:     f.wcache_en = 1'b1;
      SUB_WCACHE_OFF:    f.wcache_en = 1'b0;
      SUB_NARROW_ON:     f.narrow_en = 1'b1;
      SUB_NARROW_OFF:    f.narrow_en = 1'b0;
      SUB_APM_OFF:       f.apm_en = 1'b0;
      SUB_REL_INT_ON:    f.rel_int_en = 1'b1;
      SUB_REL_INT_OFF:   f.rel_int_en = 1'b0;
      SUB_SVC_INT_ON:    f.svc_int_en = 1'b1;
      SUB_SVC_INT_OFF:   f.svc_int_en = 1'b0;
      SUB_LOOKAHEAD_ON:  f.lookahead_en = 1'b1;
      SUB_LOOKAHEAD_OFF: f.lookahead_en = 1'b0;
      SUB_APM_ON: begin
        ab = (c == APM_RSVD_LOW) || (c == APM_RSVD_HIGH);
        if (!ab) f.apm_en = 1'b1;
        if (!ab) f.apm_level = c;
      end
      SUB_XFER_MODE: begin
        case (c[7:3])
          XT_PIO_DEFAULT: ab = c[2:0] > XM_NO_FLOW;
          XT_PIO_FLOW:    ab = c[2:0] > CAP_PIO_MAX;
          XT_MDMA:        ab = c[2:0] > CAP_MDMA_MAX;
          XT_UDMA:        ab = c[2:0] > CAP_UDMA_MAX;
          default:        ab = 1'b1;
        endcase
        if (!ab && c[7:4] == 4'h0) begin
          f.pio_mode = c[3] ? c[2:0] : 3'h0;
          f.flow_en  = c[3] | (c[2:0] == XM_DEFAULT);
        end else if (!ab) begin
          f.mdma_en = (c[7:3] == XT_MDMA);
          f.udma_en = (c[7:3] == XT_UDMA);
          if (f.mdma_en) f.mdma_mode = c[2:0];
          else f.udma_mode = c[2:0];
        end
      end
      default: ab = 1'b1;
    endcase
    return ab;
  endfunction : upd

  task automatic run_sf(input logic [7:0] s, input logic [7:0] c);
    logic [31:0] d;
    logic        ab;
    wr(OFF_FEATURE_SELECT, s);
    wr(OFF_SECTOR_COUNT, c);
    wr(OFF_COMMAND_CODE, CMD_SET_FEATURES);
    ab = upd(s, c, ef);
    @(posedge hclk);
    #1;
    if (s == SUB_WCACHE_OFF) begin
      chk({31'h0, flush_req}, 32'h1);
      if (lat > 4'h3) rd(OFF_STATUS, d);
      if (lat > 4'h3) chk({31'h0, d[7]}, 32'h1);
    end
    wait_idle(d);
    chk({31'h0, flush_req}, 32'h0);
    rd(OFF_ERROR_FLAGS, d);
    chk({31'h0, hresp}, 32'h0);
    chk(d, ab ? {24'h0, ERR_ABORT} : 32'h0);
    rd(OFF_STATUS, d);
    chk({24'h0, d[7:0] & 8'hC9}, ab ? 32'h41 : 32'h40);
    rd(OFF_SETTINGS, d);
    chk(d, {6'h0, ef});
    chk({6'h0, feat}, {6'h0, ef});
    chk({31'h0, narrow_bus}, {31'h0, ef.narrow_en});
    chk({31'h0, ready_flow_control_signal},
        {31'h0, ef.flow_en | (ef.pio_mode >= PIO_FLOW_MIN)});
    chk({31'h0, spin_down_ok},
        {31'h0, !(ef.apm_en && ef.apm_level >= APM_NO_STANDBY)});
  endtask : run_sf

  task automatic give_verdict;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    ef = FEAT_RST;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd(OFF_STATUS, v);
    chk({24'h0, v[7:0] & 8'hC9}, 32'h40);
    rd(8'h3C, v);
    chk(v, 32'h0);
    for (int a = OFF_ADDR_LOW; a <= OFF_DRIVE_SELECT; a += 4) begin
      wr(a[7:0], a[7:0] ^ 8'hA5);
      rd(a[7:0], v);
      chk(v, {24'h0, a[7:0] ^ 8'hA5});
    end
    for (int k = 0; k < 3; k++)
      for (int m = 0; m < 8; m++)
        if (CABLE_80 || TT[k] != XT_UDMA || m < 3)
          run_sf(SUB_XFER_MODE, {TT[k], m[2:0]});
    for (int i = 0; i < 27; i++) begin
      lat <= i[0] ? 4'hC : 4'h0;
      run_sf(TBL[i][15:8], TBL[i][7:0]);
    end
    dev_fault <= 1'b1;
    wr(OFF_COMMAND_CODE, CMD_SERVICE);
    wait_idle(v);
    chk({31'h0, v[5]}, 32'h1);
    dev_fault <= 1'b0;
    lat       <= 4'hF;
    rd(OFF_ERROR_FLAGS, v);
    chk(v, {24'h0, ERR_ABORT});
    chk(svc_n, 0);
    for (int e = 0; e < 2; e++) begin
      en = e[0];
      run_sf(en ? SUB_SVC_INT_ON : SUB_SVC_INT_OFF, 8'h00);
      run_sf(en ? SUB_REL_INT_ON : SUB_REL_INT_OFF, 8'h00);
      @(posedge hclk);
      bus_release <= 1'b1;
      @(posedge hclk);
      bus_release <= 1'b0;
      #1;
      chk({31'h0, int_pending}, {31'h0, en});
      rd(OFF_STATUS, v);
      #1;
      chk({31'h0, int_pending}, 32'h0);
      service_request_bit <= 1'b1;
      resume_has_data     <= 1'b1;
      wr(OFF_COMMAND_CODE, CMD_SERVICE);
      svc_exp++;
      repeat (3) @(posedge hclk);
      #1;
      chk({31'h0, int_pending}, {31'h0, en});
      chk(svc_n, svc_exp);
      rd(OFF_STATUS, v);
      service_request_bit <= 1'b0;
      chk({31'h0, v[3]}, 32'h1);
      repeat (20) @(posedge hclk);
      rd(OFF_STATUS, v);
      chk({31'h0, v[3]}, 32'h0);
    end
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge hclk);
    miscompares++;
    give_verdict();
  end
endmodule : tb_top
